// ==== dim_pkg.sv ====
// Package for the digital input function mapper: register map, reset
// values, filter times and the state record of the mapper.
// Assumes a 25 MHz clock and an Avalon-MM slave with byte addresses.
package dim_pkg;

    // ************************************************************
    // Clock and filter times
    // ************************************************************
    localparam int DIM_CLK_PERIOD_NS = 40;
    localparam int DIM_SLOW_FILTER_NS = 3000000;
    localparam int DIM_FAST_FILTER_NS = 250000;
    localparam int DIM_SLOW_CYC = DIM_SLOW_FILTER_NS / DIM_CLK_PERIOD_NS;
    localparam int DIM_FAST_CYC = DIM_FAST_FILTER_NS / DIM_CLK_PERIOD_NS;
    localparam int DIM_CNT_W = 17;
    localparam int DIM_N_TERM = 9;
    localparam int DIM_N_SLOW = 7;
    localparam int DIM_FN_MAX = 37;

    // ************************************************************
    // Register map (byte offsets)
    // ************************************************************
    localparam logic [7:0] DIM_FN_SEL_OFS = 8'h00;
    localparam logic [7:0] DIM_LG_SEL_OFS = 8'h04;
    localparam logic [7:0] DIM_TERM_STRIDE = 8'h08;
    localparam logic [7:0] DIM_CTRL_OFS = 8'h48;
    localparam logic [7:0] DIM_STATUS_OFS = 8'h4C;
    localparam logic [7:0] DIM_ACT_LO_OFS = 8'h50;
    localparam logic [7:0] DIM_ACT_HI_OFS = 8'h54;
    localparam logic [7:0] DIM_LEVEL_OFS = 8'h58;
    localparam int DIM_CTRL_RUN_BIT = 0;
    localparam int DIM_CTRL_INTFL_BIT = 1;
    localparam int DIM_STAT_DUP_BIT = 0;
    localparam int DIM_STAT_TRIG_BIT = 1;

    // Selector reset values, terminal 1 in the lowest slot
    localparam logic [8:0][5:0] DIM_FN_RST = {6'h00, 6'h1F, 6'h03, 6'h0C,
        6'h01, 6'h02, 6'h0D, 6'h0F, 6'h0E};
    localparam logic [8:0][2:0] DIM_LG_RST = '0;

    // ************************************************************
    // Logic selector modes and function codes
    // ************************************************************
    typedef enum logic [2:0] {
        DIM_LG_LOW = 3'h0, DIM_LG_HIGH = 3'h1, DIM_LG_RISE = 3'h2,
        DIM_LG_FALL = 3'h3, DIM_LG_BOTH = 3'h4
    } dim_logic_t;

    typedef enum logic [5:0] {
        DIM_FN_NONE, DIM_FN_SERVO_ENABLE, DIM_FN_FAULT_RESET,
        DIM_FN_GAIN_SWITCH, DIM_FN_CMD_SOURCE, DIM_FN_MULTI_DIR,
        DIM_FN_SEGMENT_BIT1, DIM_FN_SEGMENT_BIT2, DIM_FN_SEGMENT_BIT3,
        DIM_FN_SEGMENT_BIT4, DIM_FN_MODE_ONE, DIM_FN_MODE_TWO,
        DIM_FN_ZERO_CLAMP, DIM_FN_POS_INHIBIT, DIM_FN_FWD_OVERTRAVEL,
        DIM_FN_REV_OVERTRAVEL, DIM_FN_POS_TORQUE_LIMIT,
        DIM_FN_NEG_TORQUE_LIMIT, DIM_FN_FWD_JOG, DIM_FN_REV_JOG,
        DIM_FN_STEP_ENABLE, DIM_FN_HW_MAG_BIT1, DIM_FN_HW_MAG_BIT2,
        DIM_FN_HW_ENABLE, DIM_FN_GEAR_SELECT, DIM_FN_TORQUE_DIR,
        DIM_FN_SPEED_DIR, DIM_FN_POSITION_DIR, DIM_FN_SEG_POS_ENABLE,
        DIM_FN_INT_RELEASE, DIM_FN_UNUSED, DIM_FN_HOME_SENSOR,
        DIM_FN_HOMING_START, DIM_FN_INT_BLOCK, DIM_FN_EMERGENCY_HALT,
        DIM_FN_CLEAR_DEVIATION, DIM_FN_SPEED_LIMIT_SRC, DIM_FN_PULSE_BLOCK
    } dim_fn_t;

    // ************************************************************
    // Whole state of the mapper
    // ************************************************************
    typedef struct packed {
        logic [8:0][5:0] fn_sel;
        logic [8:0][2:0] lg_sel;
        logic [8:0][5:0] app_fn;
        logic [8:0][2:0] app_lg;
        logic [8:0][DIM_CNT_W-1:0] cnt;
        logic [8:0] filt;
        logic [8:0] prev;
        logic [37:0] fn_act;
        logic dup;
        logic int_trig;
        logic run;
        logic intfl;
        logic wait_req;
        logic [31:0] rdata;
    } dim_state_t;

endpackage : dim_pkg

// ==== dim_mapper.sv ====
// Digital input function mapper: filters nine input terminals, applies
// each terminal's logic selector and routes it to one of 37 functions.
// Assumes terminal inputs synchronous to clk and an Avalon-MM master.
//
// Operation
// (R1) Software writes function selectors 0 to 37 only
// (R2) Codes 1-16 map enable through positive torque limit
// (R3) Codes 17,18: negative torque limit, forward jog
// (R4) Codes 19-24: reverse jog through gear select
// (R5) Codes 29-37: interrupt release through pulse block
// (R6) Same function on two terminals raises fault
// (R7) Unassigned active function stays latched active
// (R8) Terminals 1-7 filtered with 3 ms
// (R9) Terminals 8-9 filtered with 0.25 ms
// (R10) Source holds ordinary pulses over 3 ms
// (R11) Source holds fast pulses over 0.25 ms
// (R12) Fixed-length mode makes terminal 9 the trigger
// (R13) Software keeps terminal 9 unassigned in that mode
// (R14) Logic selector: low, high, rise, fall, both
// (R15) Source holds opposite level 3 ms beforehand
// (R16) Selector changes apply only while drive stopped
`timescale 1ns/10ps
module dim_mapper #(
    parameter int SLOW_CYC = dim_pkg::DIM_SLOW_CYC,
    parameter int FAST_CYC = dim_pkg::DIM_FAST_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [8:0] din,
    output logic [37:0] fn_active,
    output logic dup_fault,
    output logic int_trigger
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic term_on(input logic lvl, input logic prv,
        input logic [2:0] mode);
        logic on;
        on = 1'b0;
        case (mode)
            dim_pkg::DIM_LG_LOW: on = ~lvl;
            dim_pkg::DIM_LG_HIGH: on = lvl;
            dim_pkg::DIM_LG_RISE: on = lvl & ~prv;
            dim_pkg::DIM_LG_FALL: on = ~lvl & prv;
            dim_pkg::DIM_LG_BOTH: on = lvl ^ prv;
            default: on = 1'b0;
        endcase
        return on;
    endfunction : term_on

    function automatic logic term_reg(input logic [7:0] addr);
        return addr < dim_pkg::DIM_CTRL_OFS && addr[1:0] == 2'h0;
    endfunction : term_reg

    localparam logic [dim_pkg::DIM_CNT_W-1:0] SLOW_TOP =
        dim_pkg::DIM_CNT_W'(SLOW_CYC - 1);
    localparam logic [dim_pkg::DIM_CNT_W-1:0] FAST_TOP =
        dim_pkg::DIM_CNT_W'(FAST_CYC - 1);

    dim_pkg::dim_state_t st_reg;
    dim_pkg::dim_state_t st_next;
    logic [8:0] term_act;
    logic [8:0] term_used;
    logic [37:0] fn_assigned;
    logic dup_now;
    logic [3:0] idx;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic hit;
        logic [dim_pkg::DIM_CNT_W-1:0] top;
        st_next = st_reg;
        hit = 1'b0;
        top = SLOW_TOP;
        term_act = '0;
        term_used = '0;
        fn_assigned = '0;
        dup_now = 1'b0;
        idx = avs_address[6:3];

        // Filter: a level must differ for the whole window to be taken
        for (int t = 0; t < dim_pkg::DIM_N_TERM; t++) begin
            top = (t < dim_pkg::DIM_N_SLOW) ? SLOW_TOP : FAST_TOP; // [R8] [R9]
            if (din[t] == st_reg.filt[t]) begin
                st_next.cnt[t] = '0;
            end else if (st_reg.cnt[t] >= top) begin
                st_next.filt[t] = din[t];
                st_next.cnt[t] = '0;
            end else begin
                st_next.cnt[t] = st_reg.cnt[t] + 1'b1;
            end
            term_act[t] = term_on(st_reg.filt[t], st_reg.prev[t],
                st_reg.app_lg[t]); // [R14]
            // Terminal 9 is withheld from its function in fixed-length mode
            term_used[t] = !(t == dim_pkg::DIM_N_TERM - 1 && st_reg.intfl)
                && st_reg.app_fn[t] != 6'h00; // [R12]
        end
        st_next.prev = st_reg.filt;

        // Selectors reach the mapping only while stopped
        if (!st_reg.run) begin
            st_next.app_fn = st_reg.fn_sel; // [R16]
            st_next.app_lg = st_reg.lg_sel; // [R16]
        end

        // Route terminals to functions; unassigned ones keep their value
        st_next.fn_act[0] = 1'b0;
        for (int f = 1; f <= dim_pkg::DIM_FN_MAX; f++) begin
            hit = 1'b0;
            for (int t = 0; t < dim_pkg::DIM_N_TERM; t++) begin
                if (term_used[t] && st_reg.app_fn[t] == 6'(f)) begin
                    fn_assigned[f] = 1'b1;
                    hit = hit | term_act[t]; // [R2] [R3] [R4] [R5]
                end
            end
            if (fn_assigned[f]) begin
                st_next.fn_act[f] = hit;
            end else begin
                st_next.fn_act[f] = st_reg.fn_act[f]; // [R7]
            end
        end

        // Any nonzero code seen on two terminals is a fault, except terminal 9 in fixed-length mode
        for (int i = 0; i < dim_pkg::DIM_N_TERM; i++) begin
            for (int j = i + 1; j < dim_pkg::DIM_N_TERM; j++) begin
                if (term_used[i] && term_used[j]
                    && st_reg.app_fn[i] == st_reg.app_fn[j]) begin
                    dup_now = 1'b1; // [R6]
                end
            end
        end
        st_next.dup = dup_now;
        st_next.int_trig = st_reg.intfl
            & term_act[dim_pkg::DIM_N_TERM - 1]; // [R12]

        // Bus: one wait cycle, then a single cycle with waitrequest low
        st_next.wait_req = !((avs_read || avs_write) && st_reg.wait_req);
        if (avs_read && st_reg.wait_req) begin
            st_next.rdata = '0;
            if (term_reg(avs_address) && avs_address[2]) begin
                st_next.rdata[2:0] = st_reg.lg_sel[idx];
            end else if (term_reg(avs_address)) begin
                st_next.rdata[5:0] = st_reg.fn_sel[idx];
            end else begin
                case (avs_address)
                    dim_pkg::DIM_CTRL_OFS: begin
                        st_next.rdata[dim_pkg::DIM_CTRL_RUN_BIT] = st_reg.run;
                        st_next.rdata[dim_pkg::DIM_CTRL_INTFL_BIT] =
                            st_reg.intfl;
                    end
                    dim_pkg::DIM_STATUS_OFS: begin
                        st_next.rdata[dim_pkg::DIM_STAT_DUP_BIT] = st_reg.dup;
                        st_next.rdata[dim_pkg::DIM_STAT_TRIG_BIT] =
                            st_reg.int_trig;
                    end
                    dim_pkg::DIM_ACT_LO_OFS: st_next.rdata = st_reg.fn_act[31:0];
                    dim_pkg::DIM_ACT_HI_OFS: st_next.rdata[5:0] =
                        st_reg.fn_act[37:32];
                    dim_pkg::DIM_LEVEL_OFS: st_next.rdata[8:0] = st_reg.filt;
                    default: st_next.rdata = '0;
                endcase
            end
        end
        // Only byte lane 0 carries writable bits
        if (avs_write && !st_reg.wait_req && avs_byteenable[0]) begin
            if (term_reg(avs_address) && avs_address[2]) begin
                st_next.lg_sel[idx] = avs_writedata[2:0];
            end else if (term_reg(avs_address)) begin
                // Codes above 37 are stored but match no function
                st_next.fn_sel[idx] = avs_writedata[5:0]; // [R1]
            end else if (avs_address == dim_pkg::DIM_CTRL_OFS) begin
                st_next.run = avs_writedata[dim_pkg::DIM_CTRL_RUN_BIT];
                st_next.intfl = avs_writedata[dim_pkg::DIM_CTRL_INTFL_BIT];
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '{fn_sel: dim_pkg::DIM_FN_RST,
                app_fn: dim_pkg::DIM_FN_RST, wait_req: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata = st_reg.rdata;
    assign avs_waitrequest = st_reg.wait_req;
    assign fn_active = st_reg.fn_act;
    assign dup_fault = st_reg.dup;
    assign int_trigger = st_reg.int_trig;

    // ************************************************************
    // Checks
    // ************************************************************
    filter_slow_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        $changed(st_reg.filt[0]) |-> $past(st_reg.cnt[0]) == SLOW_TOP)
        else $error("Slow terminal changed before its window");

    filter_fast_a: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
        $changed(st_reg.filt[7]) |-> $past(st_reg.cnt[7]) == FAST_TOP)
        else $error("Fast terminal changed before its window");

    dup_fault_a: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        (st_reg.app_fn[0] != 6'h00 && st_reg.app_fn[0] == st_reg.app_fn[2])
        |=> dup_fault)
        else $error("Duplicate code not flagged");

    latch_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        ##1 ((fn_active ^ $past(fn_active)) & ~$past(fn_assigned)) == '0)
        else $error("Unassigned function changed");

    map_route_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        (term_used[0] && term_act[0] && st_reg.app_fn[0] <= 6'h25)
        |=> fn_active[$past(st_reg.app_fn[0])])
        else $error("Active terminal did not raise its function");

    trig_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        (st_reg.intfl && term_act[8]) |=> int_trigger ##0
        !fn_active[0])
        else $error("Terminal 9 did not trigger");

    trig_off_a: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        !st_reg.intfl |=> !int_trigger)
        else $error("Trigger without fixed-length mode");

    rise_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
        (st_reg.app_lg[1] == dim_pkg::DIM_LG_RISE && term_act[1])
        |-> $rose(st_reg.filt[1]))
        else $error("Rising mode active without a rise");

    level_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
        st_reg.app_lg[2] == dim_pkg::DIM_LG_LOW
        |-> term_act[2] == !st_reg.filt[2])
        else $error("Low mode does not follow the level");

    apply_stop_a: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
        st_reg.run |=> $stable(st_reg.app_fn) && $stable(st_reg.app_lg))
        else $error("Selectors changed while running");

    bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Bus answer late");

    // ************************************************************
    // Checks on filters, mapping, faults, modes and the bus
    // ************************************************************
    slow_window_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        $changed(st_reg.filt[1]) |-> $past(st_reg.cnt[1]) == SLOW_TOP)
        else $error("Slow terminal 2 changed before its window");

    fast_window_a: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
        $changed(st_reg.filt[8]) |-> $past(st_reg.cnt[8]) == FAST_TOP)
        else $error("Fast terminal 9 changed before its window");

    glitch_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        din[0] == st_reg.filt[0] |=> $stable(st_reg.filt[0]))
        else $error("Filtered level moved without a difference");

    count_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        din[0] == st_reg.filt[0] |=> st_reg.cnt[0] == '0)
        else $error("Filter count kept after a glitch");

    neg_jog_map_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        (term_used[2] && term_act[2]
        && (st_reg.app_fn[2] == 6'h11 || st_reg.app_fn[2] == 6'h12))
        |=> fn_active[$past(st_reg.app_fn[2])])
        else $error("Code 17 or 18 not raised");

    gear_map_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        (term_used[2] && term_act[2]
        && st_reg.app_fn[2] >= 6'h13 && st_reg.app_fn[2] <= 6'h18)
        |=> fn_active[$past(st_reg.app_fn[2])])
        else $error("Code 19 to 24 not raised");

    homing_map_a: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
        (term_used[2] && term_act[2]
        && st_reg.app_fn[2] >= 6'h1D && st_reg.app_fn[2] <= 6'h25)
        |=> fn_active[$past(st_reg.app_fn[2])])
        else $error("Code 29 to 37 not raised");

    dup_set_a: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        dup_now |=> dup_fault)
        else $error("Duplicate seen but not flagged");

    dup_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
        !dup_now |=> !dup_fault)
        else $error("Fault stays without a duplicate");

    fall_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
        (st_reg.app_lg[1] == dim_pkg::DIM_LG_FALL && term_act[1])
        |-> $fell(st_reg.filt[1]))
        else $error("Falling mode active without a fall");

    both_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
        (st_reg.app_lg[1] == dim_pkg::DIM_LG_BOTH && term_act[1])
        |-> $changed(st_reg.filt[1]))
        else $error("Edge mode active without a change");

    high_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
        st_reg.app_lg[2] == dim_pkg::DIM_LG_HIGH
        |-> term_act[2] == st_reg.filt[2])
        else $error("High mode does not follow the level");

    apply_copy_a: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
        !st_reg.run |=> st_reg.app_fn == $past(st_reg.fn_sel))
        else $error("Selectors not applied while stopped");

    trig_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
        (st_reg.intfl && !term_act[8]) |=> !int_trigger)
        else $error("Trigger without terminal 9 activity");

    bus_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(avs_read || avs_write) |=> avs_waitrequest)
        else $error("Waitrequest low with no request");

    status_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_read && avs_waitrequest
        && avs_address == dim_pkg::DIM_STATUS_OFS)
        |=> avs_readdata[dim_pkg::DIM_STAT_DUP_BIT] == $past(dup_fault))
        else $error("Status read lost the fault");

    ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == dim_pkg::DIM_CTRL_OFS)
        |=> st_reg.run == $past(avs_writedata[dim_pkg::DIM_CTRL_RUN_BIT]))
        else $error("Control write did not land");

endmodule : dim_mapper

// ==== dim_switches.sv ====
// Model of the switches, sensors and controller outputs on the terminals.
// Assumes the bench sets the wanted levels just after a rising edge.
`timescale 1ns/10ps
module dim_switches (
    input wire logic clk,
    input wire logic [8:0] lvl_req,
    output logic [8:0] din
);
    // Contacts move only on an edge; pulse widths and settle times
    // are the bench's duty, so no short glitch is made by accident
    always @(posedge clk) begin
        din <= lvl_req;
    end
endmodule : dim_switches

// ==== dim_mapper_bench.sv ====
// Self-checking bench for the digital input function mapper.
// Assumes filter windows shortened to 8 and 4 cycles, 25 MHz clock.
`timescale 1ns/10ps
module dim_mapper_bench;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    localparam int SLOW = 8;
    localparam int FAST = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [8:0] lvl_req = 9'h000;
    logic [8:0] din;
    logic [37:0] fn_active;
    logic dup_fault;
    logic int_trigger;
    wire [38:0] obs = {int_trigger, fn_active};
    int err_total = 0;
    int checks = 0;
    int cnt;
    logic [31:0] rd;

    always #20 clk = ~clk;

    dim_switches sw (.clk(clk), .lvl_req(lvl_req), .din(din));
    dim_mapper #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) uut (.clk(clk),
        .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(4'hF),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .din(din),
        .fn_active(fn_active), .dup_fault(dup_fault),
        .int_trigger(int_trigger));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic ok, input string what);
        checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("Error at %0t ns: %s", $time, what);
        end
    endtask : chk

    // Request held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) chk(1'b0, "bus answer missing");
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic watch(input int idx, input int n);
        cnt = 0;
        repeat (n) begin
            @(posedge clk);
            if (obs[idx] === 1'b1) cnt++;
        end
    endtask : watch

    // High pulse of n cycles on terminal t, then a long low settle
    task automatic pulse(input int t, input int n, input int idx);
        int c;
        lvl_req[t] <= 1'b1;
        watch(idx, n);
        c = cnt;
        lvl_req[t] <= 1'b0;
        watch(idx, 24);
        cnt += c;
    endtask : pulse

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        logic [7:0] a[7] = '{8'h00, 8'h08, 8'h10, 8'h04, 8'h0C, 8'h50,
            8'h60};
        logic [31:0] e[7] = '{32'hE, 32'hF, 32'hD, 32'h0, 32'h0,
            32'h8000F00E, 32'h0};
        watch(0, 4);
        chk(fn_active === 38'h0080_00F00E, "default mapping");
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, a[i], 32'h0);
            chk(rd === e[i], "reset value or unmapped read");
        end
    endtask : t_reset

    task automatic t_filter;
        pulse(0, SLOW - 1, 14);
        chk(cnt == SLOW + 23, "slow glitch passed");
        pulse(7, FAST - 1, 31);
        chk(cnt == FAST + 23, "fast glitch passed");
        pulse(0, SLOW + 8, 14);
        chk(cnt == 24, "slow pulse width");
        pulse(7, FAST + 8, 31);
        chk(cnt == 24, "fast pulse width");
    endtask : t_filter

    task automatic t_logic;
        int exp_c[4] = '{20, 1, 1, 2};
        for (int m = 1; m <= 4; m++) begin
            bus(1'b1, 8'h0C, 32'(m));
            // Let the new selector reach the output before counting
            watch(15, 2);
            pulse(1, 20, 15);
            chk(cnt == exp_c[m-1], "logic selector result");
        end
        bus(1'b1, 8'h0C, 32'h0);
    endtask : t_logic

    task automatic t_codes;
        int codes[6] = '{17, 18, 19, 24, 29, 37};
        bus(1'b1, 8'h14, 32'h1);
        lvl_req[2] <= 1'b1;
        watch(0, 12);
        foreach (codes[i]) begin
            bus(1'b1, 8'h10, 32'(codes[i]));
            watch(0, 3);
            chk(fn_active[codes[i]] === 1'b1, "no map");
        end
        bus(1'b1, 8'h10, 32'h0);
        lvl_req[2] <= 1'b0;
        watch(0, 12);
        chk(fn_active[37] === 1'b1, "unassigned not latched");
    endtask : t_codes

    task automatic t_dup;
        bus(1'b1, 8'h10, 32'hE);
        watch(0, 3);
        chk(dup_fault === 1'b1, "duplicate not flagged");
        bus(1'b0, 8'h4C, 32'h0);
        chk(rd[0] === 1'b1, "status lacks duplicate");
        bus(1'b1, 8'h10, 32'h0);
        watch(0, 3);
        chk(dup_fault === 1'b0, "duplicate stuck");
    endtask : t_dup

    // Selector written while running must wait for the stop
    task automatic t_run;
        lvl_req[2] <= 1'b1;
        watch(0, 12);
        bus(1'b1, 8'h48, 32'h1);
        bus(1'b1, 8'h10, 32'h14);
        watch(0, 6);
        chk(fn_active[20] === 1'b0, "applied while running");
        bus(1'b1, 8'h48, 32'h0);
        watch(0, 3);
        chk(fn_active[20] === 1'b1, "not applied at stop");
    endtask : t_run

    task automatic t_trig;
        // Edge logic first, so the low default never trips the trigger
        bus(1'b1, 8'h44, 32'h2);
        bus(1'b1, 8'h48, 32'h2);
        pulse(8, 12, 38);
        chk(cnt == 1, "fixed-length trigger pulses");
    endtask : t_trig

    // ************************************************************
    // Sequence, watchdog and verdict
    // ************************************************************
    task automatic give_verdict;
        $display("Checks %0d, errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_filter();
        t_logic();
        t_codes();
        t_dup();
        t_run();
        t_trig();
        give_verdict();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        give_verdict();
    end
endmodule : dim_mapper_bench
